// *** rtl/ssd_consts.svh ***
// timing constants and status byte layout for the sensor indicator block
// assumes a 20 MHz system clock
`ifndef SSD_CONSTS_SVH
`define SSD_CONSTS_SVH
`define SSD_CLK_HZ         20000000
`define SSD_WARN_MIN       30
`define SSD_PROT_MIN       10
`define SSD_YEL_FLASH_HZ   1
`define SSD_DIAG_CLK_HZ    2
`define SSD_WARN_CYC       (`SSD_WARN_MIN * 60 * 64'd20000000)
`define SSD_PROT_CYC       (`SSD_PROT_MIN * 60 * 64'd20000000)
`define SSD_YEL_HALF_CYC   (`SSD_CLK_HZ / (2 * `SSD_YEL_FLASH_HZ))
`define SSD_DIAG_HALF_CYC  (`SSD_CLK_HZ / (2 * `SSD_DIAG_CLK_HZ))
`define SSD_PULSE_HALF_CYC 4000000
`define SSD_BURST_GAP_CYC  30000000
`define SSD_ST_OUT_EN      0
`define SSD_ST_ACT_ID      1
`define SSD_ST_INPUTS      4
`define SSD_ST_LIMIT       5
`define SSD_ST_WARN        6
`define SSD_ST_ERROR       7
`endif

// *** rtl/ssd_pkg.sv ***
// types for the sensor status and diagnostic indicator block
// assumes nothing of its surroundings
package ssd_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_RUN   = 6'b000010,
    ST_WARN  = 6'b000100,
    ST_ERR   = 6'b001000,
    ST_TEACH = 6'b010000,
    ST_PROT  = 6'b100000
  } ssd_state_t;
endpackage

// *** rtl/ssd_indicator.sv ***
// status, indicator and safety output sequencing of a coded door sensor
// assumes fault detectors and actuator reader on the same clock
`timescale 1ns/1ns
`include "ssd_consts.svh"
module ssd_indicator
  import ssd_pkg::*;
#(
  parameter longint WARN_CYC  = `SSD_WARN_CYC,
  parameter longint PROT_CYC  = `SSD_PROT_CYC,
  parameter int     PULSE_CYC = `SSD_PULSE_HALF_CYC,
  parameter int     GAP_CYC   = `SSD_BURST_GAP_CYC,
  parameter int     YEL_CYC   = `SSD_YEL_HALF_CYC,
  parameter int     DIAG_CYC  = `SSD_DIAG_HALF_CYC
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       CLK_EN_I,
  input  wire logic       SAFETY_INPUT_A_I,
  input  wire logic       SAFETY_INPUT_B_I,
  input  wire logic       ACT_PRESENT_I,
  input  wire logic [7:0] ACT_CODE_I,
  input  wire logic       ACT_LIMIT_I,
  input  wire logic       PERMANENT_INDIVIDUAL_CODING_I,
  input  wire logic       RETEACHABLE_INDIVIDUAL_CODING_I,
  input  wire logic       TEACH_REQ_I,
  input  wire logic [2:0] FAULT_CODE_I,
  input  wire logic       FAULT_WARN_I,
  input  wire logic       FAULT_INTERNAL_I,
  input  wire logic       ERR_RESET_REQ_I,
  output logic            LED_GREEN_O,
  output logic            LED_YELLOW_O,
  output logic            LED_RED_O,
  output logic            DIAG_OUT_O,
  output logic            SAFETY_OUTPUT_A_O,
  output logic            SAFETY_OUTPUT_B_O,
  output logic [7:0]      STATUS_O
);
  if (PULSE_CYC < 1 || GAP_CYC < 1 || WARN_CYC < 1 || PROT_CYC < 1 ||
      YEL_CYC < 1 || DIAG_CYC < 1) begin : g_bad_timing
    $error("ssd_indicator: timing parameters must be positive");
  end
  default clocking dcb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  // ==========================================================
  // input synchronisers, change taken when stages two and three agree
  logic [2:0] sa_q, sb_q;
  logic       in_a_q, in_b_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      sa_q   <= 3'h0;
      sb_q   <= 3'h0;
      in_a_q <= 1'b0;
      in_b_q <= 1'b0;
    end else if (CLK_EN_I) begin
      sa_q <= {sa_q[1:0], SAFETY_INPUT_A_I};
      sb_q <= {sb_q[1:0], SAFETY_INPUT_B_I};
      if (sa_q[1] == sa_q[2]) in_a_q <= sa_q[2];
      if (sb_q[1] == sb_q[2]) in_b_q <= sb_q[2];
    end
  end
  wire inputs_live = in_a_q & in_b_q;

  // ==========================================================
  // actuator coding
  logic       learned_q;
  logic [7:0] code_q;
  wire individual = PERMANENT_INDIVIDUAL_CODING_I |
                    RETEACHABLE_INDIVIDUAL_CODING_I;
  wire act_valid = ACT_PRESENT_I &
                   (!individual || (learned_q && ACT_CODE_I == code_q));
  wire teach_ok  = RETEACHABLE_INDIVIDUAL_CODING_I & TEACH_REQ_I;

  // ==========================================================
  // state machine
  ssd_state_t state_q;
  logic [63:0] tmr_q;
  logic        rst_req_q;
  wire fault_any = FAULT_INTERNAL_I | (FAULT_CODE_I != 3'h0);
  wire rst_fall  = rst_req_q & ~ERR_RESET_REQ_I;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state_q   <= ST_IDLE;
      tmr_q     <= 64'h0;
      learned_q <= 1'b0;
      code_q    <= 8'h00;
      rst_req_q <= 1'b0;
    end else if (CLK_EN_I) begin
      rst_req_q <= ERR_RESET_REQ_I;
      tmr_q     <= tmr_q + 64'h1;
      case (state_q)
        ST_IDLE, ST_RUN: begin
          tmr_q <= 64'h0;
          if (fault_any) state_q <= ST_ERR;
          else if (individual && !learned_q && ACT_PRESENT_I)
            state_q <= ST_TEACH;
          else if (teach_ok && learned_q) state_q <= ST_TEACH;
          else if (FAULT_WARN_I && act_valid) state_q <= ST_WARN;
          else if (act_valid) state_q <= ST_RUN;
          else state_q <= ST_IDLE;
        end
        ST_WARN: begin
          if (fault_any || tmr_q >= 64'(WARN_CYC - 1)) begin
            state_q <= ST_ERR;
            tmr_q   <= 64'h0;
          end else if (!FAULT_WARN_I) state_q <= ST_IDLE;
        end
        ST_ERR: begin
          if (!fault_any && !FAULT_WARN_I &&
              (rst_fall || !ACT_PRESENT_I))
            state_q <= ST_IDLE;
        end
        ST_TEACH: begin
          tmr_q <= 64'h0;
          if (ACT_PRESENT_I) begin
            code_q <= ACT_CODE_I;
            if (learned_q) state_q <= ST_PROT;
            else state_q <= ST_IDLE;
            learned_q <= 1'b1;
          end
        end
        ST_PROT: begin
          if (tmr_q >= 64'(PROT_CYC - 1)) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // blink sources
  logic [31:0] ycnt_q, dcnt_q, bcnt_q;
  logic        yblink_q, dblink_q, bpulse_q, bgap_q;
  logic [2:0]  bnum_q;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ycnt_q   <= 32'h0;
      dcnt_q   <= 32'h0;
      yblink_q <= 1'b0;
      dblink_q <= 1'b0;
    end else if (CLK_EN_I) begin
      ycnt_q <= ycnt_q + 32'h1;
      dcnt_q <= dcnt_q + 32'h1;
      if (ycnt_q >= 32'(YEL_CYC - 1)) begin
        ycnt_q   <= 32'h0;
        yblink_q <= ~yblink_q;
      end
      if (dcnt_q >= 32'(DIAG_CYC - 1)) begin
        dcnt_q   <= 32'h0;
        dblink_q <= ~dblink_q;
      end
    end
  end

  // burst generator: count pulses, then a long pause
  wire [2:0] burst_n = (FAULT_CODE_I == 3'h0) ? 3'h1 : FAULT_CODE_I;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      bcnt_q   <= 32'h0;
      bpulse_q <= 1'b0;
      bgap_q   <= 1'b0;
      bnum_q   <= 3'h0;
    end else if (CLK_EN_I) begin
      bcnt_q <= bcnt_q + 32'h1;
      if (bgap_q) begin
        if (bcnt_q >= 32'(GAP_CYC - 1)) begin
          bcnt_q <= 32'h0;
          bgap_q <= 1'b0;
        end
      end else if (bcnt_q >= 32'(PULSE_CYC - 1)) begin
        bcnt_q   <= 32'h0;
        bpulse_q <= ~bpulse_q;
        if (bpulse_q) begin
          if (bnum_q + 3'h1 >= burst_n) begin
            bnum_q <= 3'h0;
            bgap_q <= 1'b1;
          end else bnum_q <= bnum_q + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // outputs, all registered
  wire run_en = inputs_live & act_valid;
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      LED_GREEN_O       <= 1'b0;
      LED_YELLOW_O      <= 1'b0;
      LED_RED_O         <= 1'b0;
      DIAG_OUT_O        <= 1'b0;
      SAFETY_OUTPUT_A_O <= 1'b0;
      SAFETY_OUTPUT_B_O <= 1'b0;
      STATUS_O          <= 8'h00;
    end else if (CLK_EN_I) begin
      LED_GREEN_O       <= 1'b0;
      LED_YELLOW_O      <= 1'b0;
      LED_RED_O         <= 1'b0;
      DIAG_OUT_O        <= 1'b0;
      SAFETY_OUTPUT_A_O <= 1'b0;
      SAFETY_OUTPUT_B_O <= 1'b0;
      case (state_q)
        ST_IDLE: LED_GREEN_O <= 1'b1;
        ST_RUN: begin
          LED_YELLOW_O      <= ACT_LIMIT_I ? yblink_q : 1'b1;
          DIAG_OUT_O        <= ACT_LIMIT_I ? dblink_q : 1'b1;
          SAFETY_OUTPUT_A_O <= run_en;
          SAFETY_OUTPUT_B_O <= run_en;
        end
        ST_WARN: begin
          LED_RED_O         <= bpulse_q;
          SAFETY_OUTPUT_A_O <= run_en;
          SAFETY_OUTPUT_B_O <= run_en;
        end
        ST_ERR: LED_RED_O <= FAULT_INTERNAL_I ? 1'b1 : bpulse_q;
        ST_TEACH: begin
          LED_RED_O    <= 1'b1;
          LED_YELLOW_O <= yblink_q;
        end
        ST_PROT: LED_GREEN_O <= yblink_q;
        default: LED_GREEN_O <= 1'b0;
      endcase
      STATUS_O <= 8'h00;
      STATUS_O[`SSD_ST_OUT_EN] <= run_en &
          (state_q == ST_RUN || state_q == ST_WARN);
      STATUS_O[`SSD_ST_ACT_ID] <= act_valid;
      STATUS_O[`SSD_ST_INPUTS] <= inputs_live;
      STATUS_O[`SSD_ST_LIMIT]  <= (state_q == ST_RUN) & ACT_LIMIT_I;
      STATUS_O[`SSD_ST_WARN]   <= (state_q == ST_WARN);
      STATUS_O[`SSD_ST_ERROR]  <= (state_q == ST_ERR);
    end
  end

  // ==========================================================
  // assertions
  a_err_outputs_off: assert property (
    CLK_EN_I && state_q == ST_ERR |=> !SAFETY_OUTPUT_A_O && !DIAG_OUT_O)
    else $error("outputs active in error");
  a_teach_red_on: assert property (
    CLK_EN_I && state_q == ST_TEACH |=> LED_RED_O && !LED_GREEN_O)
    else $error("teach indication wrong");
  a_idle_green_only: assert property (
    CLK_EN_I && state_q == ST_IDLE |=> LED_GREEN_O && !SAFETY_OUTPUT_B_O)
    else $error("idle indication wrong");
  a_outputs_gated: assert property (
    $past(CLK_EN_I) && SAFETY_OUTPUT_A_O |->
      $past(inputs_live) && $past(act_valid))
    else $error("safety output without cause");
  a_warn_keeps_on: assert property (
    CLK_EN_I && state_q == ST_WARN && run_en |=> SAFETY_OUTPUT_A_O
      && !DIAG_OUT_O)
    else $error("warning outputs wrong");
  a_run_yellow: assert property (
    CLK_EN_I && state_q == ST_RUN && !ACT_LIMIT_I |=> LED_YELLOW_O
      && DIAG_OUT_O)
    else $error("run indication wrong");
  a_prot_dark: assert property (
    CLK_EN_I && state_q == ST_PROT |=> !LED_RED_O && !SAFETY_OUTPUT_A_O)
    else $error("protection indication wrong");
  a_status_err: assert property (
    CLK_EN_I && state_q == ST_ERR |=> STATUS_O[7] && !STATUS_O[0])
    else $error("status error bit wrong");
  a_err_internal: assert property (
    CLK_EN_I && state_q == ST_ERR && FAULT_INTERNAL_I |=> LED_RED_O)
    else $error("internal fault red not steady");
  c_run: cover property (@(posedge SYS_CLK_I) state_q == ST_RUN);
  c_warn_err: cover property (@(posedge SYS_CLK_I)
    state_q == ST_WARN ##1 state_q == ST_ERR);
  c_prot: cover property (@(posedge SYS_CLK_I) state_q == ST_PROT);
  c_err_clear: cover property (@(posedge SYS_CLK_I)
    state_q == ST_ERR ##1 state_q == ST_IDLE);
endmodule

// *** dv/ssd_safety_monitor.sv ***
// far-side model: dual-channel safety monitor fed by the safety outputs
// assumes the sensor outputs arrive on the system clock
`timescale 1ns/1ns
module ssd_safety_monitor #(
  parameter int TOL_CYC = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic out_a_i,
  input  wire logic out_b_i,
  output logic      stop_o
);
  int unsigned low_cnt_q;
  // ======================================================================
  // dropout filter
  // short test dropouts are ignored, no cross check between the channels
  always_ff @(posedge clk_i) begin
    if (rst_i || (out_a_i && out_b_i)) begin
      low_cnt_q <= 0;
    end else if (low_cnt_q <= TOL_CYC) begin
      low_cnt_q <= low_cnt_q + 1;
    end
  end
  assign stop_o = (low_cnt_q > TOL_CYC);
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the sensor indicator block
// assumes ssd_indicator with short counts and the monitor model
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [14:0] v; logic [14:0] m;} ssd_note_t;
  logic       clk = 0, rst = 1, ina = 1, inb = 1, act = 0, lim = 0;
  logic       perm = 0, fwarn = 0, fint = 0, errrst = 0;
  logic       cen = 1, retch = 0, treq = 0;
  logic [7:0] code = 8'h00;
  logic [2:0] fcode = 3'h0;
  logic       g, y, r, d, oa, ob, stop;
  logic [7:0] st;
  int         miscompares = 0, num_checks = 0, seed = 32'h2e55, n, k;
  ssd_note_t  notes[$];
  event       look_ev;
  always #25 clk = ~clk;
  localparam int WARN_T  = 200;
  localparam int PROT_T  = 100;
  localparam int PULSE_T = 2;
  localparam int GAP_T   = 10;
  localparam int YHALF   = 10;
  localparam int DHALF   = YHALF / 2; // 2 Hz diag against 1 Hz yellow
  ssd_indicator #(.WARN_CYC(WARN_T), .PROT_CYC(PROT_T), .PULSE_CYC(PULSE_T),
    .GAP_CYC(GAP_T), .YEL_CYC(YHALF), .DIAG_CYC(DHALF)) dut (
    .SYS_CLK_I(clk), .RST_I(rst), .CLK_EN_I(cen),
    .SAFETY_INPUT_A_I(ina), .SAFETY_INPUT_B_I(inb), .ACT_PRESENT_I(act),
    .ACT_CODE_I(code), .ACT_LIMIT_I(lim), .PERMANENT_INDIVIDUAL_CODING_I(perm),
    .RETEACHABLE_INDIVIDUAL_CODING_I(retch), .TEACH_REQ_I(treq),
    .FAULT_CODE_I(fcode), .FAULT_WARN_I(fwarn), .FAULT_INTERNAL_I(fint),
    .ERR_RESET_REQ_I(errrst), .LED_GREEN_O(g), .LED_YELLOW_O(y),
    .LED_RED_O(r), .DIAG_OUT_O(d), .SAFETY_OUTPUT_A_O(oa),
    .SAFETY_OUTPUT_B_O(ob), .STATUS_O(st));
  ssd_safety_monitor mon (.clk_i(clk), .rst_i(rst), .out_a_i(oa),
    .out_b_i(ob), .stop_o(stop));
  // ======================================================================
  // checking
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(look_ev) begin
    ssd_note_t nt;
    nt = notes.pop_front();
    check({stop, g, y, r, d, oa, ob, st} & nt.m, nt.v & nt.m);
  end
  // ======================================================================
  // stimulus helpers
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  // o and om order: green, yellow, red, diag, out a, out b
  task automatic expect_out(input logic [5:0] o, input logic [5:0] om,
                            input logic [7:0] s, input logic [7:0] sm);
    notes.push_back('{v: {~(o[1] & o[0]), o, s}, m: {om[1] & om[0], om, sm}});
    -> look_ev;
  endtask
  task automatic do_reset();
    rst = 1;
    step(6);
    rst = 0;
  endtask
  task automatic burst(output int cnt);
    int lo, j;
    logic prev;
    cnt = 0;
    lo = 0;
    for (j = 0; j < 400 && lo < 7; j++) begin
      step(1);
      lo = (r === 1'b1) ? 0 : lo + 1;
    end
    lo = 0;
    for (j = 0; j < 400 && lo < 7; j++) begin
      prev = r;
      step(1);
      if (r === 1'b1 && prev !== 1'b1) cnt++;
      lo = (r === 1'b1) ? 0 : lo + 1;
    end
  endtask
  // spacing of the first two changes of yellow, diag or green
  task automatic half(input int sel, output int len);
    int   j, t0;
    logic prev, cur;
    len = 0;
    t0 = -1;
    prev = (sel == 0) ? y : ((sel == 1) ? d : g);
    for (j = 0; j < 30; j++) begin
      step(1);
      cur = (sel == 0) ? y : ((sel == 1) ? d : g);
      if (cur !== prev && len == 0) begin
        if (t0 < 0) t0 = j;
        else len = j - t0;
      end
      prev = cur;
    end
  endtask
  // ======================================================================
  // scenarios
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    do_reset();
    step(8);
    expect_out(6'b100000, 6'b111111, 8'h10, 8'hff);
    code = 8'($random(seed));
    act = 1;
    step(8);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    cen = 0;
    act = 0;
    step(10);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    cen = 1;
    step(8);
    expect_out(6'b100000, 6'b111111, 8'h10, 8'hff);
    act = 1;
    step(8);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    inb = 0;
    step(10);
    expect_out(6'b000000, 6'b000011, 8'h00, 8'h11);
    inb = 1;
    lim = 1;
    step(10);
    expect_out(6'b000011, 6'b001011, 8'h33, 8'hff);
    half(0, n);
    check(15'(n), 15'(YHALF));
    half(1, n);
    check(15'(n), 15'(DHALF));
    lim = 0;
    errrst = 1;
    fwarn = 1;
    step(8);
    expect_out(6'b000011, 6'b100111, 8'h51, 8'hc1);
    step(200);
    expect_out(6'b000000, 6'b110111, 8'h80, 8'h81);
    fwarn = 0;
    step(2);
    errrst = 0;
    step(8);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    for (k = 1; k <= 5; k++) begin
      errrst = 1;
      fcode = k[2:0];
      step(8);
      expect_out(6'b000000, 6'b110111, 8'h90, 8'h91);
      burst(n);
      check(n[14:0], k[14:0]);
      fcode = 3'h0;
      step(2);
      errrst = 0;
      step(8);
      expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    end
    fint = 1;
    step(8);
    for (k = 0; k < 12; k++) begin
      expect_out(6'b001000, 6'b001011, 8'h80, 8'h81);
      step(1);
    end
    fint = 0;
    act = 0;
    step(8);
    expect_out(6'b100000, 6'b111111, 8'h10, 8'hff);
    perm = 1;
    do_reset();
    code = 8'($random(seed));
    act = 1;
    step(30);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    act = 0;
    step(8);
    code = code ^ 8'h01;
    act = 1;
    step(30);
    expect_out(6'b100000, 6'b100111, 8'h10, 8'hff);
    treq = 1;
    step(8);
    expect_out(6'b100000, 6'b100111, 8'h10, 8'hff);
    treq = 0;
    perm = 0;
    retch = 1;
    do_reset();
    code = 8'($random(seed));
    step(30);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    code = code ^ 8'h80;
    treq = 1;
    step(8);
    expect_out(6'b000000, 6'b011111, 8'h12, 8'hff);
    treq = 0;
    half(2, n);
    check(15'(n), 15'(YHALF));
    step(PROT_T - 40);
    expect_out(6'b000000, 6'b011111, 8'h12, 8'hff);
    step(8);
    expect_out(6'b010111, 6'b111111, 8'h13, 8'hff);
    step(2);
    finish_test();
  end
endmodule
